/* hdl/fpr_pkg.sv */
package fpr_pkg;

	// register indices on the serial link (8-bit register address space)
	localparam logic [7:0] FPR_ADDR_LOWER = 8'h00;
	localparam logic [7:0] FPR_ADDR_UPPER = 8'h01;
	localparam logic [7:0] FPR_ADDR_RANGE = 8'h02;

	// field layout
	localparam int FPR_WORD_W      = 26;
	localparam int FPR_LOWER_W     = 16;
	localparam int FPR_UPPER_W     = 10;
	localparam int FPR_OE_BIT      = 10;
	localparam int FPR_RANGE_W     = 4;
	localparam int FPR_PPM_W       = 19;

	// reset values
	localparam logic [15:0] FPR_LOWER_RST = 16'h0000;
	localparam logic [9:0]  FPR_UPPER_RST = 10'h000;
	localparam logic        FPR_OE_RST    = 1'b0;

	// serial link framing
	localparam logic [6:0] FPR_DEV_ADDR_DEF = 7'h60;
	localparam logic [3:0] FPR_BIT_ACK      = 4'h8;
	localparam logic [3:0] FPR_BIT_LAST     = 4'h7;

	typedef enum logic [2:0] {
		FPR_ST_IDLE = 3'b000,
		FPR_ST_ADDR = 3'b001,
		FPR_ST_REG  = 3'b010,
		FPR_ST_WR   = 3'b011,
		FPR_ST_RD   = 3'b100
	} fpr_state_t;

	// applied pull setting handed to the synthesis logic
	typedef struct packed {
		logic signed [25:0] word;
		logic [3:0]         range;
		logic [18:0]        half_range_ppm_x100;
	} fpr_pull_t;

	// half pull range in hundredths of a ppm for each code
	function automatic logic [18:0] fpr_range_ppm(input logic [3:0] code);
		case (code)
			4'h0: fpr_range_ppm = 19'h0_0271;
			4'h1: fpr_range_ppm = 19'h0_03E8;
			4'h2: fpr_range_ppm = 19'h0_04E2;
			4'h3: fpr_range_ppm = 19'h0_09C4;
			4'h4: fpr_range_ppm = 19'h0_1388;
			4'h5: fpr_range_ppm = 19'h0_1F40;
			4'h6: fpr_range_ppm = 19'h0_2710;
			4'h7: fpr_range_ppm = 19'h0_30D4;
			4'h8: fpr_range_ppm = 19'h0_3A98;
			4'h9: fpr_range_ppm = 19'h0_4E20;
			4'hA: fpr_range_ppm = 19'h0_9C40;
			4'hB: fpr_range_ppm = 19'h0_EA60;
			4'hC: fpr_range_ppm = 19'h1_3880;
			4'hD: fpr_range_ppm = 19'h1_D4C0;
			4'hE: fpr_range_ppm = 19'h2_7100;
			default: fpr_range_ppm = 19'h4_E200;
		endcase
	endfunction

endpackage

/* hdl/fpr_bank.sv */
// Summary of operation
// - upper register bits 15:11 read zero, ignore writes
// - software output enable bit 10, reset off
// - pin-controlled enable mode ignores software bit
// - upper bits 9:0 hold top ten word bits
// - whole pull word resets to zero
// - pull word is signed two's complement
// - upper-word write applies new pull word; range write applies new range at once
// - range register bits 15:4 read zero
// - four-bit code selects half pull range
// - range loads factory value, software may overwrite
// - enable bit reads back last written value
// - lower word at 0x00, read-write, reset zero
// - sixteen-bit data, two bytes, high byte first
`timescale 1ns/1ps
`default_nettype none

module fpr_bank #(
	parameter logic [6:0] DEV_ADDR      = fpr_pkg::FPR_DEV_ADDR_DEF,
	parameter logic [3:0] FACTORY_RANGE = 4'h9
) (
	// clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              rst_n_i,
	// serial link, open drain data
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe_o,
	// output enable pin and mode strap
	input  wire logic              oe_pin_mode_i,
	input  wire logic              oe_pin_i,
	// pull logic side
	output fpr_pkg::fpr_pull_t     pull_cfg_o,
	output logic                   pull_update_o,
	output logic                   output_enable_o
);
	import fpr_pkg::*;

	logic [2:0]       scl_sync_reg;
	logic [2:0]       sda_sync_reg;
	logic [1:0]       oe_pin_sync_reg;
	fpr_state_t       state_reg;
	logic [3:0]       bit_cnt_reg;
	logic [7:0]       rx_reg;
	logic [7:0]       tx_reg;
	logic [7:0]       ptr_reg;
	logic [7:0]       hi_byte_reg;
	logic             byte_sel_reg;
	logic             ack_reg;
	logic             sda_oe_reg;
	logic [15:0]      lower_reg;
	logic [9:0]       upper_reg;
	logic             oe_sw_reg;
	logic [3:0]       range_reg;
	fpr_pull_t        pull_reg;
	logic             update_reg;
	logic             out_en_reg;
	logic             scl_rise;
	logic             scl_fall;
	logic             start_det;
	logic             stop_det;
	logic             wr_commit;
	logic [15:0]      wr_data;
	logic [7:0]       rd_byte;
	logic [15:0]      rd_word;

	// read view of one register; unmapped addresses read zero
	function automatic logic [15:0] read_reg(input logic [7:0] a);
		case (a)
			FPR_ADDR_LOWER: read_reg = lower_reg;
			FPR_ADDR_UPPER: read_reg = {5'h00, oe_sw_reg, upper_reg};
			FPR_ADDR_RANGE: read_reg = {12'h000, range_reg};
			default: read_reg = 16'h0000;
		endcase
	endfunction

	// link pins cross into sys_clk; only stage 1 and 2 feed logic
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			oe_pin_sync_reg <= 2'h0;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
			oe_pin_sync_reg <= {oe_pin_sync_reg[0], oe_pin_i};
		end
	end

	assign scl_rise  = scl_sync_reg[1] & ~scl_sync_reg[2];
	assign scl_fall  = ~scl_sync_reg[1] & scl_sync_reg[2];
	assign start_det = scl_sync_reg[2] & scl_sync_reg[1] & ~sda_sync_reg[1] & sda_sync_reg[2];
	assign stop_det  = scl_sync_reg[2] & scl_sync_reg[1] & sda_sync_reg[1] & ~sda_sync_reg[2];

	// second byte of a word completes a write
	assign wr_commit = scl_fall && (bit_cnt_reg == FPR_BIT_LAST) && (state_reg == FPR_ST_WR)
		&& byte_sel_reg;
	assign wr_data = {hi_byte_reg, rx_reg};
	// process form so register contents, not only the pointer, wake it
	always_comb begin
		rd_word = read_reg(ptr_reg);
	end
	assign rd_byte = byte_sel_reg ? rd_word[7:0] : rd_word[15:8];

	// bit position and sampling of incoming data
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			bit_cnt_reg <= 4'h0;
			rx_reg <= 8'h00;
		end else if (start_det) begin
			// clock fall that closes a start is no bit; it wraps to 0
			bit_cnt_reg <= 4'hF;
		end else begin
			if (scl_rise && bit_cnt_reg != FPR_BIT_ACK) begin
				rx_reg <= {rx_reg[6:0], sda_sync_reg[1]};
			end
			if (scl_fall) begin
				bit_cnt_reg <= (bit_cnt_reg == FPR_BIT_ACK) ? 4'h0 : bit_cnt_reg + 4'h1;
			end
		end
	end

	// byte-level transaction control
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_reg <= FPR_ST_IDLE;
			ack_reg <= 1'b0;
			ptr_reg <= 8'h00;
			hi_byte_reg <= 8'h00;
			byte_sel_reg <= 1'b0;
			tx_reg <= 8'hFF;
		end else if (start_det) begin
			state_reg <= FPR_ST_ADDR;
			ack_reg <= 1'b0;
			byte_sel_reg <= 1'b0;
			tx_reg <= 8'hFF;
		end else if (stop_det) begin
			state_reg <= FPR_ST_IDLE;
			ack_reg <= 1'b0;
			tx_reg <= 8'hFF;
		end else if (scl_fall && bit_cnt_reg == FPR_BIT_LAST) begin
			// byte complete: decide acknowledge
			case (state_reg)
				FPR_ST_ADDR: begin
					if (rx_reg[7:1] == DEV_ADDR) begin
						ack_reg <= 1'b1;
						state_reg <= rx_reg[0] ? FPR_ST_RD : FPR_ST_REG;
						byte_sel_reg <= 1'b0;
					end else begin
						state_reg <= FPR_ST_IDLE;
					end
				end
				FPR_ST_REG: begin
					ack_reg <= 1'b1;
					ptr_reg <= rx_reg;
					byte_sel_reg <= 1'b0;
					state_reg <= FPR_ST_WR;
				end
				FPR_ST_WR: begin
					ack_reg <= 1'b1;
					hi_byte_reg <= rx_reg;
					byte_sel_reg <= ~byte_sel_reg;
					// address rolls 255 to 0 by natural wrap
					if (byte_sel_reg) begin
						ptr_reg <= ptr_reg + 8'h01;
					end
				end
				FPR_ST_RD: begin
					tx_reg <= 8'hFF;
				end
				default: begin
					state_reg <= FPR_ST_IDLE;
				end
			endcase
		end else if (scl_fall && bit_cnt_reg == FPR_BIT_ACK) begin
			ack_reg <= 1'b0;
			// master nack does not stop the device from sending on
			if (state_reg == FPR_ST_RD) begin
				tx_reg <= rd_byte;
				byte_sel_reg <= ~byte_sel_reg;
				if (byte_sel_reg) begin
					ptr_reg <= ptr_reg + 8'h01;
				end
			end
		end else if (scl_fall && state_reg == FPR_ST_RD) begin
			tx_reg <= {tx_reg[6:0], 1'b1};
		end
	end

	// open drain: pull low for ack or a zero data bit
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			sda_oe_reg <= 1'b0;
		end else begin
			sda_oe_reg <= ack_reg | ((state_reg == FPR_ST_RD) && (bit_cnt_reg != FPR_BIT_ACK)
				&& !tx_reg[7]);
		end
	end

	// lower word storage
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			// lower sixteen bits of word reset zero
			lower_reg <= FPR_LOWER_RST;
		end else if (wr_commit && ptr_reg == FPR_ADDR_LOWER) begin
			lower_reg <= wr_data;
		end
	end

	// upper word and software enable
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			upper_reg <= FPR_UPPER_RST;
			oe_sw_reg <= FPR_OE_RST;
		end else if (wr_commit && ptr_reg == FPR_ADDR_UPPER) begin
			// bits 9:0 are the word's top bits
			upper_reg <= wr_data[FPR_UPPER_W-1:0];
			// bit stored regardless of enable mode
			oe_sw_reg <= wr_data[FPR_OE_BIT];
		end
	end

	// range code; reset stands in for power-up here
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			range_reg <= FACTORY_RANGE;
		end else if (wr_commit && ptr_reg == FPR_ADDR_RANGE) begin
			range_reg <= wr_data[FPR_RANGE_W-1:0];
		end
	end

	// applied setting; lower-only writes leave the pull unchanged
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			pull_reg.word <= '0;
			pull_reg.range <= FACTORY_RANGE;
			pull_reg.half_range_ppm_x100 <= fpr_range_ppm(FACTORY_RANGE);
			update_reg <= 1'b0;
		end else begin
			// only upper write starts new pull
			update_reg <= wr_commit && ptr_reg == FPR_ADDR_UPPER;
			if (wr_commit && ptr_reg == FPR_ADDR_UPPER) begin
				// whole word applied in one cycle
				pull_reg.word <= signed'({wr_data[FPR_UPPER_W-1:0], lower_reg});
			end
			// range code maps to half range
			pull_reg.range <= range_reg;
			pull_reg.half_range_ppm_x100 <= fpr_range_ppm(range_reg);
		end
	end

	// enable source selection
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			out_en_reg <= 1'b0;
		end else begin
			out_en_reg <= oe_pin_mode_i ? oe_pin_sync_reg[1] : oe_sw_reg;
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe_o = sda_oe_reg;
	assign pull_cfg_o = pull_reg;
	assign pull_update_o = update_reg;
	assign output_enable_o = out_en_reg;

endmodule

`default_nettype wire

/* verif/fpr_bank_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module fpr_bank_monitor (
	// clock and reset
	input wire logic               sys_clk_i,
	input wire logic               rst_n_i,
	// link and pins
	input wire logic               scl_i,
	input wire logic               sda_i,
	input wire logic               sda_o,
	input wire logic               sda_oe_o,
	input wire logic               oe_pin_mode_i,
	input wire logic               oe_pin_i,
	// pull logic side
	input wire fpr_pkg::fpr_pull_t pull_cfg_o,
	input wire logic               pull_update_o,
	input wire logic               output_enable_o
);
	import fpr_pkg::*;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	a_update_follows: assert property (
		$changed(pull_cfg_o.word) |-> pull_update_o) else $error("no pulse with word change");
	a_update_single: assert property (
		pull_update_o |=> !pull_update_o) else $error("update pulse too long");
	a_word_scl_low: assert property (
		$changed(pull_cfg_o.word) |-> !scl_i) else $error("word changed outside commit");
	a_range_lowest: assert property (
		$stable(pull_cfg_o.range) && pull_cfg_o.range == 4'h0
		|-> pull_cfg_o.half_range_ppm_x100 == 19'h0_0271) else $error("lowest range wrong");
	a_pin_high: assert property (
		(oe_pin_mode_i && oe_pin_i)[*5] |-> output_enable_o) else $error("pin mode ignored");
	a_ack_held: assert property (
		$rose(sda_oe_o) |-> sda_oe_o[*8]) else $error("data line drive too short");
	a_sw_oe_write: assert property (
		(!oe_pin_mode_i)[*4] ##0 $changed(output_enable_o)
		|-> pull_update_o || $past(pull_update_o)) else $error("enable moved without write");
	a_reset_clear: assert property (
		$rose(rst_n_i) |-> pull_cfg_o.word == '0 && !pull_update_o) else $error("bad reset state");
endmodule
`default_nettype wire

/* verif/fpr_i2c_master.sv */
`timescale 1ns/1ps
`default_nettype none
module fpr_i2c_master (
	// bench clock
	input wire logic clk_i,
	// serial link, open drain data
	output logic     scl_o,
	output logic     sda_oe_o,
	input wire logic sda_i
);
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// data moves only while clock low
	task automatic bit_io(input logic b, output logic r);
		w(3);
		sda_oe_o = !b;
		w(7);
		scl_o = 1'b1;
		w(5);
		r = sda_i;
		w(5);
		scl_o = 1'b0;
	endtask
	task automatic start();
		w(3);
		sda_oe_o = 1'b0;
		w(2);
		scl_o = 1'b1;
		w(5);
		sda_oe_o = 1'b1;
		w(5);
		scl_o = 1'b0;
	endtask
	task automatic stop();
		w(3);
		sda_oe_o = 1'b1;
		w(7);
		scl_o = 1'b1;
		w(5);
		sda_oe_o = 1'b0;
		w(10);
	endtask
	task automatic xfer(input logic [7:0] d, input logic m9, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(m9, r);
		ack = !r;
	endtask
	// last read byte: stop stands in the ninth slot, the only time the device lets go
	task automatic xfer_stop(output logic [7:0] q);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			q[i] = r;
		end
		stop();
	endtask
endmodule
`default_nettype wire

/* verif/test_freq_pull_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module test_freq_pull_register_bank;
	import fpr_pkg::*;
	logic        sys_clk_i;
	logic        rst_n_i;
	logic        scl;
	logic        m_oe;
	logic        d_oe;
	logic        mode;
	logic        pin;
	logic        upd;
	logic        oe;
	logic        a;
	logic [7:0]  r;
	logic [15:0] q;
	fpr_pull_t   cfg;
	int          num_errors;
	int          checks_done;
	int          n_upd;
	// pulled-up open drain wire
	wire logic   sda = !(d_oe | m_oe);
	logic [18:0] ppm [16] = '{19'h0_0271, 19'h0_03E8, 19'h0_04E2, 19'h0_09C4, 19'h0_1388,
		19'h0_1F40, 19'h0_2710, 19'h0_30D4, 19'h0_3A98, 19'h0_4E20, 19'h0_9C40, 19'h0_EA60,
		19'h1_3880, 19'h1_D4C0, 19'h2_7100, 19'h4_E200};
	fpr_bank #(.FACTORY_RANGE(4'h5)) i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(d_oe), .oe_pin_mode_i(mode),
		.oe_pin_i(pin), .pull_cfg_o(cfg), .pull_update_o(upd), .output_enable_o(oe));
	fpr_i2c_master i_mst (.clk_i(sys_clk_i), .scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda));
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) if (upd === 1'b1) n_upd++;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic xb(input logic [7:0] d, input logic m9, output logic [7:0] v);
		logic k;
		i_mst.xfer(d, m9, v, k);
		chk("ack", k, 1'b1);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [15:0] d);
		i_mst.start();
		xb({FPR_DEV_ADDR_DEF, 1'b0}, 1'b1, r);
		xb(ad, 1'b1, r);
		xb(d[15:8], 1'b1, r);
		xb(d[7:0], 1'b1, r);
		i_mst.stop();
		if (ad == FPR_ADDR_UPPER) i_mst.w(3300);
	endtask
	task automatic rd(input logic [7:0] ad, output logic [15:0] v);
		i_mst.start();
		xb({FPR_DEV_ADDR_DEF, 1'b0}, 1'b1, r);
		xb(ad, 1'b1, r);
		i_mst.start();
		xb({FPR_DEV_ADDR_DEF, 1'b1}, 1'b1, r);
		xb(8'hFF, 1'b0, v[15:8]);
		// device sends on after any ninth bit
		i_mst.xfer_stop(v[7:0]);
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#700_000;
		num_errors++;
		end_of_test();
	end
	initial begin
		rst_n_i = 1'b0;
		mode = 1'b0;
		pin = 1'b0;
		n_upd = 0;
		i_mst.w(4);
		rst_n_i = 1'b1;
		i_mst.w(4);
		rd(FPR_ADDR_LOWER, q);
		chk("lower", q, 16'h0000);
		rd(FPR_ADDR_UPPER, q);
		chk("upper", q, 16'h0000);
		rd(FPR_ADDR_RANGE, q);
		chk("range", q, 16'h0005);
		chk("enable", oe, 1'b0);
		for (int c = 0; c < 16; c++) begin
			wr(FPR_ADDR_RANGE, 16'hFFF0 | 16'(c));
			rd(FPR_ADDR_RANGE, q);
			chk("range rd", q, 32'(c));
			chk("range", cfg.range, 32'(c));
			chk("ppm", cfg.half_range_ppm_x100, ppm[c]);
		end
		wr(FPR_ADDR_RANGE, 16'h0009);
		// +90 ppm of 200 gives 0xE6_6666, low word first
		wr(FPR_ADDR_LOWER, 16'h6666);
		chk("word", cfg.word[25:0], 26'h000_0000);
		chk("pulses", n_upd, 32'h0000_0000);
		wr(FPR_ADDR_UPPER, 16'hFCE6);
		chk("word", cfg.word[25:0], 26'h0E6_6666);
		chk("pulses", n_upd, 32'h0000_0001);
		chk("enable", oe, 1'b1);
		rd(FPR_ADDR_UPPER, q);
		chk("upper", q, 16'h04E6);
		rd(FPR_ADDR_LOWER, q);
		chk("lower", q, 16'h6666);
		wr(FPR_ADDR_LOWER, 16'h0000);
		wr(FPR_ADDR_UPPER, 16'h0780);
		chk("word", cfg.word[25:0], 26'h380_0000);
		chk("sign", cfg.word < 0, 1'b1);
		mode = 1'b1;
		wr(FPR_ADDR_UPPER, 16'h0380);
		wr(FPR_ADDR_UPPER, 16'h0780);
		chk("enable", oe, 1'b0);
		rd(FPR_ADDR_UPPER, q);
		chk("upper", q, 16'h0780);
		pin = 1'b1;
		i_mst.w(8);
		chk("enable", oe, 1'b1);
		mode = 1'b0;
		wr(FPR_ADDR_UPPER, 16'h0380);
		chk("enable", oe, 1'b0);
		wr(8'h05, 16'h1234);
		rd(8'h05, q);
		chk("unmapped", q, 16'h0000);
		i_mst.start();
		i_mst.xfer({FPR_DEV_ADDR_DEF ^ 7'h01, 1'b0}, 1'b1, r, a);
		chk("nack", a, 1'b0);
		i_mst.stop();
		end_of_test();
	end
endmodule
bind fpr_bank fpr_bank_monitor i_mon (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.oe_pin_mode_i(oe_pin_mode_i), .oe_pin_i(oe_pin_i), .pull_cfg_o(pull_cfg_o),
	.pull_update_o(pull_update_o), .output_enable_o(output_enable_o));
`default_nettype wire
